// [mac_apb_register_port.sv]
// Purpose: APB register port of the 10G MAC with PHY-side port presence by interface type
// Assumes: requester keeps the APB setup/access protocol; PHY pins are asynchronous
// Notes:   one wait state per access; gearbox clocks are sampled, not used as clocks
`timescale 1ns/100ps
module mac_apb_register_port #(
    parameter int phy_interface_type = mac_apb_pkg::TYPE_XGMII // 1: KR raw, 2: XGMII
) (
    input  wire logic        core_clk,              // APB clock, 100 MHz
    input  wire logic        rst_b,                 // async reset, active low
    input  wire logic [15:0] paddr,                 // APB byte address
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB enable strobe
    input  wire logic        pwrite,                // APB direction, high = write
    input  wire logic [31:0] pwdata,                // APB write data
    output logic      [31:0] prdata,                // APB read data
    output logic             pready,                // APB ready
    output logic      [63:0] xgmii_tx_data_out,     // XGMII transmit data
    output logic      [7:0]  xgmii_tx_ctrl_out,     // XGMII transmit control
    input  wire logic [63:0] xgmii_rx_data_in,      // XGMII receive data
    input  wire logic [7:0]  xgmii_rx_ctrl_in,      // XGMII receive control
    input  wire logic [63:0] gearbox_rx_data_in,    // gearbox receive data
    input  wire logic        gearbox_tx_clk_in,     // gearbox transmit lane clock
    input  wire logic        gearbox_rx_clk_in,     // gearbox receive lane clock
    input  wire logic        gearbox_rx_valid_in,   // gearbox receive valid
    input  wire logic [31:0] raw_lane_rx_data_in,   // raw receive data (KR)
    input  wire logic        raw_lane_rx_ready_in,  // raw receive ready (KR)
    input  wire logic        raw_lane_rx_enable_in  // raw receive enable (KR)
);
    localparam int SYNC_W = 64 + 8 + 64 + 1 + 1 + 1 + 32 + 1 + 1;
    localparam bit IS_XGMII = (phy_interface_type == mac_apb_pkg::TYPE_XGMII);
    localparam bit IS_KR    = (phy_interface_type == mac_apb_pkg::TYPE_KR);

    logic [SYNC_W-1:0] pinsSync;
    logic [63:0]       xrxData;
    logic [7:0]        xrxCtrl;
    logic [63:0]       gbxData;
    logic              txClkS;
    logic              rxClkS;
    logic              gbxValid;
    logic [31:0]       rawData;
    logic              rawReady;
    logic              rawEnable;
    logic              txClkLast;
    logic              rxClkLast;
    logic [31:0]       scratch;
    logic [63:0]       txDataReg;
    logic [7:0]        txCtrlReg;
    logic [63:0]       gbxCapture;
    logic [63:0]       xrxCapture;
    logic [7:0]        xrxCtrlCapture;
    logic [31:0]       rawCapture;
    logic [1:0]        status;

    // all PHY pins pass two flops before any logic sees them
    sync_two_stage #(.WIDTH(SYNC_W)) pinSync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .asyncIn  ({xgmii_rx_data_in, xgmii_rx_ctrl_in, gearbox_rx_data_in,
                    gearbox_tx_clk_in, gearbox_rx_clk_in, gearbox_rx_valid_in,
                    raw_lane_rx_data_in, raw_lane_rx_ready_in, raw_lane_rx_enable_in}),
        .syncOut  (pinsSync)
    );

    // unpack the synced bundle
    assign {xrxData, xrxCtrl, gbxData, txClkS, rxClkS, gbxValid,
            rawData, rawReady, rawEnable} = pinsSync;

    // APB decode: access cycle taken while ready is still low
    wire accessStart = psel & penable & ~pready;
    wire writeFire   = accessStart & pwrite;
    wire readFire    = accessStart & ~pwrite;
    wire hitScratch  = (paddr == mac_apb_pkg::OFS_SCRATCH);
    wire hitIfType   = (paddr == mac_apb_pkg::OFS_IFTYPE);
    wire hitTxdLo    = (paddr == mac_apb_pkg::OFS_TXD_LO);
    wire hitTxdHi    = (paddr == mac_apb_pkg::OFS_TXD_HI);
    wire hitTxc      = (paddr == mac_apb_pkg::OFS_TXC);
    wire hitGbxLo    = (paddr == mac_apb_pkg::OFS_GBX_LO);
    wire hitGbxHi    = (paddr == mac_apb_pkg::OFS_GBX_HI);
    wire hitXrxLo    = (paddr == mac_apb_pkg::OFS_XRX_LO);
    wire hitXrxHi    = (paddr == mac_apb_pkg::OFS_XRX_HI);
    wire hitXrxc     = (paddr == mac_apb_pkg::OFS_XRXC);
    wire hitRaw      = (paddr == mac_apb_pkg::OFS_RAW);
    wire hitStatus   = (paddr == mac_apb_pkg::OFS_STATUS);
    wire addrHit     = hitScratch | hitIfType | hitTxdLo | hitTxdHi | hitTxc | hitGbxLo
                     | hitGbxHi | hitXrxLo | hitXrxHi | hitXrxc | hitRaw | hitStatus;

    // read selection; anything not decoded returns zero
    wire [31:0] readMux =
        hitScratch ? scratch                                   :
        hitIfType  ? 32'(phy_interface_type)                   :
        hitTxdLo   ? txDataReg[31:0]                           :
        hitTxdHi   ? txDataReg[63:32]                          :
        hitTxc     ? {24'h00_0000, txCtrlReg}                  :
        hitGbxLo   ? gbxCapture[31:0]                          :
        hitGbxHi   ? gbxCapture[63:32]                         :
        hitXrxLo   ? xrxCapture[31:0]                          :
        hitXrxHi   ? xrxCapture[63:32]                         :
        hitXrxc    ? {24'h00_0000, xrxCtrlCapture}             :
        hitRaw     ? rawCapture                                :
        hitStatus  ? {30'h0000_0000, status}                   :
                     mac_apb_pkg::RST_WORD;

    // gearbox lane clocks: rising edges seen after synchronisation
    wire txClkRise   = txClkS & ~txClkLast;
    wire rxClkRise   = rxClkS & ~rxClkLast;
    wire gbxTake     = rxClkRise & gbxValid;
    wire rawTake     = IS_KR & rawReady & rawEnable;
    wire stClearGbx  = writeFire & hitStatus & pwdata[mac_apb_pkg::ST_GBX_SEEN];
    wire stClearRaw  = writeFire & hitStatus & pwdata[mac_apb_pkg::ST_RAW_SEEN];

    // ready pulses one cycle after the first access cycle; data loads with it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata <= mac_apb_pkg::RST_WORD;
        end else begin
            pready <= accessStart;
            if (readFire) begin
                prdata <= readMux;
            end
        end
    end

    // software-written registers, stored as the access is taken
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            scratch   <= mac_apb_pkg::RST_WORD;
            txDataReg <= mac_apb_pkg::RST_XGMII;
            txCtrlReg <= mac_apb_pkg::XGMII_IDLE_C;
        end else begin
            if (writeFire & hitScratch) begin
                scratch <= pwdata;
            end
            if (writeFire & hitTxdLo) begin
                txDataReg[31:0] <= pwdata;
            end
            if (writeFire & hitTxdHi) begin
                txDataReg[63:32] <= pwdata;
            end
            if (writeFire & hitTxc) begin
                txCtrlReg <= pwdata[7:0];
            end
        end
    end

    // edge history and receive captures; sticky status where a set beats a clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            txClkLast      <= 1'b0;
            rxClkLast      <= 1'b0;
            gbxCapture     <= mac_apb_pkg::RST_XGMII;
            xrxCapture     <= mac_apb_pkg::RST_XGMII;
            xrxCtrlCapture <= mac_apb_pkg::RST_CTRL;
            rawCapture     <= mac_apb_pkg::RST_WORD;
            status         <= 2'h0;
        end else begin
            txClkLast <= txClkS;
            rxClkLast <= rxClkS;
            if (gbxTake) begin
                gbxCapture <= gbxData;
            end
            if (IS_XGMII) begin
                xrxCapture     <= xrxData;
                xrxCtrlCapture <= xrxCtrl;
            end
            if (rawTake) begin
                rawCapture <= rawData;
            end
            status[mac_apb_pkg::ST_GBX_SEEN] <= gbxTake |
                (status[mac_apb_pkg::ST_GBX_SEEN] & ~stClearGbx);
            status[mac_apb_pkg::ST_RAW_SEEN] <= rawTake |
                (status[mac_apb_pkg::ST_RAW_SEEN] & ~stClearRaw);
        end
    end

    // transmit lane: presented on the tx lane clock, held at zero when absent
    generate
        if (IS_XGMII) begin : gTxPresent
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    xgmii_tx_data_out <= mac_apb_pkg::RST_XGMII;
                    xgmii_tx_ctrl_out <= mac_apb_pkg::RST_CTRL;
                end else if (txClkRise) begin
                    xgmii_tx_data_out <= txDataReg;
                    xgmii_tx_ctrl_out <= txCtrlReg;
                end
            end
        end else begin : gTxAbsent
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    xgmii_tx_data_out <= mac_apb_pkg::RST_XGMII;
                    xgmii_tx_ctrl_out <= mac_apb_pkg::RST_CTRL;
                end else begin
                    xgmii_tx_data_out <= mac_apb_pkg::RST_XGMII;
                    xgmii_tx_ctrl_out <= mac_apb_pkg::RST_CTRL;
                end
            end
        end
    endgenerate

    // protocol and datapath checks
    chk_ready_low_access: assert property (@(posedge core_clk) disable iff (!rst_b)
        (psel && penable && !$past(penable)) |-> !pready)
        else $error("ready high in first access cycle");
    chk_ready_single_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
        pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_ready_after_access: assert property (@(posedge core_clk) disable iff (!rst_b)
        (psel && penable && !pready) |=> pready)
        else $error("access not completed after one wait cycle");
    chk_read_data_valid: assert property (@(posedge core_clk) disable iff (!rst_b)
        (psel && penable && !pready && !pwrite) |=> (pready && prdata == $past(readMux)))
        else $error("read data not valid with ready");
    chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        (psel && penable && !pready && !pwrite && !addrHit) |=> (pready && prdata == 32'h0))
        else $error("unmapped read not zero or stalled");
    chk_scratch_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        (psel && penable && !pready && pwrite && hitScratch) |=> scratch == $past(pwdata))
        else $error("scratch write lost");
    chk_tx_data_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
        (IS_XGMII && txClkRise) |=> xgmii_tx_data_out == $past(txDataReg))
        else $error("tx data not updated on lane clock");
    chk_tx_ctrl_absent: assert property (@(posedge core_clk) disable iff (!rst_b)
        !IS_XGMII |-> (xgmii_tx_ctrl_out == 8'h00 && xgmii_tx_data_out == 64'h0))
        else $error("tx outputs driven while absent");
    chk_raw_absent: assert property (@(posedge core_clk) disable iff (!rst_b)
        !IS_KR |-> rawCapture == 32'h0)
        else $error("raw capture active outside KR");
    chk_gbx_capture: assert property (@(posedge core_clk) disable iff (!rst_b)
        gbxTake |=> (gbxCapture == $past(gbxData) && status[mac_apb_pkg::ST_GBX_SEEN]))
        else $error("gearbox word not captured");

    cov_read_done: cover property (@(posedge core_clk) disable iff (!rst_b)
        psel && penable && pready && !pwrite);
    cov_write_done: cover property (@(posedge core_clk) disable iff (!rst_b)
        psel && penable && pready && pwrite);
    cov_back_to_back: cover property (@(posedge core_clk) disable iff (!rst_b)
        (psel && pready) ##1 (psel && !penable) ##1 (psel && penable));
    cov_gbx_take: cover property (@(posedge core_clk) disable iff (!rst_b) gbxTake);
endmodule

// [mac_apb_pkg.sv]
// Purpose: shared constants for the MAC register port (offsets, widths, reset values)
// Assumes: 32-bit APB data, 16-bit byte address, one aligned word per register
// Notes:   PHY-side widths are fixed at the MAC core's pin widths
package mac_apb_pkg;
    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 32;
    localparam int          XGMII_W      = 64;
    localparam int          XGMII_CTRL_W = 8;
    localparam int          GEARBOX_W    = 64;
    localparam int          RAW_W        = 32;
    localparam int          TYPE_KR      = 1;
    localparam int          TYPE_XGMII   = 2;
    // register offsets (byte addresses)
    localparam logic [15:0] OFS_SCRATCH  = 16'h0000;
    localparam logic [15:0] OFS_IFTYPE   = 16'h0004;
    localparam logic [15:0] OFS_TXD_LO   = 16'h0008;
    localparam logic [15:0] OFS_TXD_HI   = 16'h000C;
    localparam logic [15:0] OFS_TXC      = 16'h0010;
    localparam logic [15:0] OFS_GBX_LO   = 16'h0014;
    localparam logic [15:0] OFS_GBX_HI   = 16'h0018;
    localparam logic [15:0] OFS_XRX_LO   = 16'h001C;
    localparam logic [15:0] OFS_XRX_HI   = 16'h0020;
    localparam logic [15:0] OFS_XRXC     = 16'h0024;
    localparam logic [15:0] OFS_RAW      = 16'h0028;
    localparam logic [15:0] OFS_STATUS   = 16'h002C;
    // status bit positions
    localparam int          ST_GBX_SEEN  = 0;
    localparam int          ST_RAW_SEEN  = 1;
    // reset values
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [63:0] RST_XGMII    = 64'h0000_0000_0000_0000;
    localparam logic [7:0]  RST_CTRL     = 8'h00;
    localparam logic [7:0]  XGMII_IDLE_C = 8'hFF;
    // pin synchroniser depth is fixed at two stages
    localparam int          SYNC_STAGES  = 2;
endpackage

// [sync_two_stage.sv]
// Purpose: two-flop synchroniser for a bundle of pin inputs
// Assumes: each bit is an independent level or is qualified later by a synced valid
// Notes:   the first stage feeds only the second stage
`timescale 1ns/100ps
module sync_two_stage #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk, // sampling clock
    input  wire logic             rst_b,    // async reset, active low
    input  wire logic [WIDTH-1:0] asyncIn,  // pin level from another domain
    output logic      [WIDTH-1:0] syncOut   // level safe to use in core_clk domain
);
    logic [WIDTH-1:0] stage1;

    // metastability guard: stage1 is read by stage two only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// [mac_apb_requester_model.sv]
// Purpose: APB requester model that drives the MAC register port
// Assumes: xfer is called at a falling edge of core_clk, one transfer at a time
// Notes:   released address and data lines show the inverse of their last value, never a stale copy
`timescale 1ns/100ps
module mac_apb_requester_model (
    input  wire logic        core_clk, // APB clock
    input  wire logic        pready,   // ready from the port
    input  wire logic [31:0] prdata,   // read data from the port
    output logic      [15:0] paddr,    // byte address
    output logic             psel,     // select
    output logic             penable,  // enable strobe
    output logic             pwrite,   // direction, high = write
    output logic      [31:0] pwdata    // write data
);
    logic held;

    // idle bus at time zero
    initial begin
        held = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
    end

    // one transfer; keep leaves select up for an immediate follow-on
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        input logic keep, output logic [31:0] rd, output int waits);
        if (!held) begin
            @(negedge core_clk);
        end
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(negedge core_clk);
        penable <= 1'b1;
        waits = 0;
        // everything held until ready is sampled high at a rising edge
        do begin
            @(posedge core_clk);
            waits++;
        end while (pready !== 1'b1 && waits < 20);
        rd = prdata;
        @(negedge core_clk);
        held = keep;
        if (!keep) begin
            penable <= 1'b0;
            psel <= 1'b0;
            paddr <= ~a;
            pwdata <= ~d;
        end
    endtask
endmodule

// [mac_apb_register_port_tb_top.sv]
// Purpose: self-checking bench for the MAC APB register port
// Assumes: u_dut is interface type 2, a second port is type 1; lane clocks are slow levels
// Notes:   raw lane pins must be ignored by u_dut and captured by the second port
`timescale 1ns/100ps
module mac_apb_register_port_tb_top;
    logic        coreClk = 1'b0;
    logic        rstB = 1'b0;
    logic [15:0] paddr;
    logic        psel, penable, pwrite, pready, txClk = 1'b0, rxClk = 1'b0, rxValid = 1'b0;
    logic [31:0] pwdata, prdata, rawData = 32'h0000_0000, rd;
    logic [63:0] txData, gbxData = 64'h0, xrxData = 64'h0;
    logic [7:0]  txCtrl, xrxCtrl = 8'h00;
    logic        rawReady = 1'b0, rawEnable = 1'b0;
    int          nErrors = 0, cmpCount = 0;
    logic [31:0] prdataKr;
    logic        readyKr;
    logic [63:0] txDataKr;
    logic [7:0]  txCtrlKr;
    int          krReady = 0;

    always #5 coreClk = ~coreClk;

    mac_apb_requester_model u_req (.core_clk(coreClk), .pready(pready), .prdata(prdata),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

    mac_apb_register_port #(.phy_interface_type(2)) u_dut (.core_clk(coreClk), .rst_b(rstB),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .xgmii_tx_data_out(txData),
        .xgmii_tx_ctrl_out(txCtrl), .xgmii_rx_data_in(xrxData), .xgmii_rx_ctrl_in(xrxCtrl),
        .gearbox_rx_data_in(gbxData), .gearbox_tx_clk_in(txClk), .gearbox_rx_clk_in(rxClk),
        .gearbox_rx_valid_in(rxValid), .raw_lane_rx_data_in(rawData),
        .raw_lane_rx_ready_in(rawReady), .raw_lane_rx_enable_in(rawEnable));

    // raw-lane variant shares the bus; the requester only listens to u_dut,
    // so this port's answers are watched directly
    mac_apb_register_port #(.phy_interface_type(mac_apb_pkg::TYPE_KR)) u_dut_kr (
        .core_clk(coreClk), .rst_b(rstB),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdataKr), .pready(readyKr), .xgmii_tx_data_out(txDataKr),
        .xgmii_tx_ctrl_out(txCtrlKr), .xgmii_rx_data_in(xrxData), .xgmii_rx_ctrl_in(xrxCtrl),
        .gearbox_rx_data_in(gbxData), .gearbox_tx_clk_in(txClk), .gearbox_rx_clk_in(rxClk),
        .gearbox_rx_valid_in(rxValid), .raw_lane_rx_data_in(rawData),
        .raw_lane_rx_ready_in(rawReady), .raw_lane_rx_enable_in(rawEnable));

    // ready pulses of the second port, counted at the edge that samples them
    always @(posedge coreClk) begin
        if (readyKr === 1'b1) krReady <= krReady + 1;
    end

    task automatic print_verdict();
        if (nErrors == 0 && cmpCount > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one access; a hung ready ends the run, otherwise exactly one wait state
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                          input logic keep, input logic [31:0] exp);
        int waits;
        int start;
        start = krReady;
        u_req.xfer(wr, a, d, keep, rd, waits);
        if (waits >= 20) begin
            nErrors++;
            print_verdict();
        end
        check(64'(waits), 64'd2, "ready latency");
        check(64'(krReady - start), 64'd1, "second port ready pulses");
        if (!wr) check(64'(rd), 64'(exp), "read data");
    endtask

    // lane clocks stay in each level long enough to be sampled
    task automatic lane_pulse(input logic tx);
        if (tx) txClk = 1'b1;
        else rxClk = 1'b1;
        repeat (4) @(negedge coreClk);
        txClk = 1'b0;
        rxClk = 1'b0;
        repeat (4) @(negedge coreClk);
    endtask

    task automatic t_reset();
        check({prdata, 31'h0, pready}, 64'h0, "read side at reset");
        check({txCtrl, txData[55:0]}, 64'h0, "tx pins at reset");
    endtask

    task automatic t_scratch();
        access(1'b1, mac_apb_pkg::OFS_SCRATCH, 32'hA5C3_0F96, 1'b1, 32'h0);
        access(1'b0, mac_apb_pkg::OFS_SCRATCH, 32'h0, 1'b1, 32'hA5C3_0F96);
        access(1'b0, mac_apb_pkg::OFS_SCRATCH, 32'h0, 1'b0, 32'hA5C3_0F96);
    endtask

    task automatic t_map();
        access(1'b1, mac_apb_pkg::OFS_IFTYPE, 32'hFFFF_FFFF, 1'b0, 32'h0);
        access(1'b0, mac_apb_pkg::OFS_IFTYPE, 32'h0, 1'b0, 32'(mac_apb_pkg::TYPE_XGMII));
        check(64'(prdataKr), 64'(mac_apb_pkg::TYPE_KR), "second port type");
        access(1'b0, 16'h0002, 32'h0, 1'b0, 32'h0);
        access(1'b0, 16'hFFFC, 32'h0, 1'b0, 32'h0);
    endtask

    task automatic t_tx();
        lane_pulse(1'b1);
        check({txCtrl, txData[55:0]}, 64'hFF00_0000_0000_0000, "tx idle");
        access(1'b1, mac_apb_pkg::OFS_TXD_LO, 32'h89AB_CDEF, 1'b0, 32'h0);
        access(1'b1, mac_apb_pkg::OFS_TXD_HI, 32'h0123_4567, 1'b0, 32'h0);
        access(1'b1, mac_apb_pkg::OFS_TXC, 32'h0000_005A, 1'b0, 32'h0);
        lane_pulse(1'b1);
        check(txData, 64'h0123_4567_89AB_CDEF, "tx data");
        check(64'(txCtrl), 64'h5A, "tx ctrl");
        check(txDataKr, 64'h0, "absent tx data");
        check(64'(txCtrlKr), 64'h0, "absent tx ctrl");
    endtask

    task automatic t_gearbox();
        gbxData = 64'hFEDC_BA98_7654_3210;
        rxValid = 1'b1;
        repeat (4) @(negedge coreClk);
        lane_pulse(1'b0);
        rxValid = 1'b0;
        access(1'b0, mac_apb_pkg::OFS_GBX_LO, 32'h0, 1'b0, 32'h7654_3210);
        access(1'b0, mac_apb_pkg::OFS_GBX_HI, 32'h0, 1'b0, 32'hFEDC_BA98);
        access(1'b0, mac_apb_pkg::OFS_STATUS, 32'h0, 1'b0, 32'h1);
        access(1'b1, mac_apb_pkg::OFS_STATUS, 32'h1, 1'b0, 32'h0);
        access(1'b0, mac_apb_pkg::OFS_STATUS, 32'h0, 1'b0, 32'h0);
    endtask

    task automatic t_xgmii_rx();
        xrxData = 64'h1122_3344_5566_7788;
        xrxCtrl = 8'h81;
        rawData = 32'hDEAD_0001;
        rawReady = 1'b1;
        rawEnable = 1'b1;
        repeat (6) @(negedge coreClk);
        access(1'b0, mac_apb_pkg::OFS_XRX_LO, 32'h0, 1'b0, 32'h5566_7788);
        access(1'b0, mac_apb_pkg::OFS_XRX_HI, 32'h0, 1'b0, 32'h1122_3344);
        access(1'b0, mac_apb_pkg::OFS_XRXC, 32'h0, 1'b0, 32'h81);
        access(1'b0, mac_apb_pkg::OFS_RAW, 32'h0, 1'b0, 32'h0);
        check(64'(prdataKr), 64'hDEAD_0001, "raw capture");
        access(1'b0, mac_apb_pkg::OFS_STATUS, 32'h0, 1'b0, 32'h0);
        check(64'(prdataKr), 64'(1) << mac_apb_pkg::ST_RAW_SEEN, "raw seen status");
    endtask

    // main sequence: reset for two cycles, then each scenario
    initial begin
        repeat (2) @(negedge coreClk);
        t_reset();
        rstB = 1'b1;
        t_scratch();
        t_map();
        t_tx();
        t_gearbox();
        t_xgmii_rx();
        print_verdict();
    end
endmodule
